// File: design/fsp_pkg.sv
/*
 fsp_pkg: constants shared by the serial flash status, guard and read logic.
 Assumes: included before fsp_link_if, fsp_link and fsp_top.
*/
package fsp_pkg;

   // ****************************
   // command codes
   // ****************************
   localparam logic [7:0] CMD_STAT_RD = 8'h05;
   localparam logic [7:0] CMD_STAT_WR = 8'h01;
   localparam logic [7:0] CMD_ARR_RD  = 8'h03;
   localparam logic [7:0] CMD_WR_EN   = 8'h06;
   localparam logic [7:0] CMD_WR_DIS  = 8'h04;
   localparam logic [7:0] CMD_PROG    = 8'h02;
   localparam logic [7:0] CMD_SECT_ER = 8'hD8;
   localparam logic [7:0] CMD_BULK_ER = 8'hC7;

   // ****************************
   // status byte layout
   // ****************************
   localparam int         BIT_BUSY   = 0;
   localparam int         BIT_WLATCH = 1;
   localparam int         BIT_GUARD0 = 2;
   localparam int         BIT_GUARD1 = 3;
   localparam int         BIT_LOCK   = 7;
   localparam logic [7:0] STAT_WMASK = 8'h8C; // writable nonvolatile bits
   localparam logic [7:0] STAT_RST   = 8'h00;

   // ****************************
   // frame bit counts and array
   // ****************************
   localparam logic [5:0] CNT_CMD  = 6'h08;
   localparam logic [5:0] CNT_WRD  = 6'h10;
   localparam logic [5:0] CNT_ADDR = 6'h20;
   localparam logic [5:0] CNT_WRAP = 6'h27;
   localparam int         MEM_AW   = 21;
   localparam int         SECT_AW  = 16;
   localparam logic [7:0] ERASED   = 8'hFF;

   // ****************************
   // internal cycle timing
   // ****************************
   localparam int CLK_NS  = 8;
   localparam int TW_NS   = 5000;
   localparam int TPP_NS  = 1500;
   localparam int TW_CYC  = (TW_NS + CLK_NS - 1) / CLK_NS;
   localparam int TPP_CYC = (TPP_NS + CLK_NS - 1) / CLK_NS;

   // internal cycle states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_WRSR  = 4'h2,
      ST_PROG  = 4'h4,
      ST_ERASE = 4'h8
   } fsp_cyc_e;

endpackage

// File: design/fsp_link_if.sv
/*
 fsp_link_if: carries frame results from the serial clock side to the core,
 and status and array data back.
 Assumes: cmd, bcnt, addr and dseen are only read by the core while select is high; rd_addr is read during frames.
*/
`timescale 1ns/1ps
interface fsp_link_if;
   logic [7:0]  cmd;
   logic [5:0]  bcnt;
   logic [23:0] addr;
   logic        dseen;
   logic [20:0] rd_addr;
   logic [7:0]  rd_data;
   logic [7:0]  status;

   modport link (output cmd, bcnt, addr, dseen, rd_addr,
                 input  rd_data, status);
   modport core (input  cmd, bcnt, addr, dseen, rd_addr,
                 output rd_data, status);
endinterface

// File: design/fsp_link.sv
/*
 fsp_link: serial clock side of the flash. Shifts in command, address and
 data on rising edges, shifts status or array bytes out on falling edges.
 Assumes: serial clock runs only while select is low; the core reads the
 frame fields only after it has seen select high.
*/
`timescale 1ns/1ps
module fsp_link (
   // link pins
   input  wire logic sck_i,
   input  wire logic sel_n_i,
   input  wire logic si_i,
   input  wire logic rst_i,
   // core side
   fsp_link_if.link  lnk,
   // serial output
   output logic      so_o,
   output logic      so_oe_n_o
);
   logic       frm_rst;
   logic       in_frame_q;
   logic [5:0] bcnt_q, bcnt_d;
   logic [7:0] cmd_q;
   logic [23:0] addr_q;
   logic       dseen_q;
   logic       busy_q;
   logic [7:0] s1_q, s2_q, s3_q, stab_q;
   logic [7:0] sr_q;
   logic       so_q, oe_n_q;
   logic [20:0] rda_q;
   logic       is_stat, is_rd, bstart;
   logic [7:0] nbyte;

   // ****************************
   // input side
   // ****************************
   // deselect ends the frame without needing another clock edge
   assign frm_rst = rst_i | sel_n_i;
   assign bcnt_d  = !in_frame_q ? 6'h01 :
                    (bcnt_q == fsp_pkg::CNT_WRAP) ? fsp_pkg::CNT_ADDR :
                    bcnt_q + 6'h01;

   // first rising edge after select falls starts the count
   always_ff @(posedge sck_i or posedge frm_rst) begin
      if (frm_rst) in_frame_q <= 1'b0;
      else         in_frame_q <= 1'b1;
   end

   // fields survive deselect so the core can read them
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         bcnt_q  <= 6'h00;
         cmd_q   <= 8'h00;
         addr_q  <= 24'h000000;
         dseen_q <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         bcnt_q  <= bcnt_d;
         dseen_q <= in_frame_q & (dseen_q | (bcnt_q == fsp_pkg::CNT_WRAP));
         if (bcnt_d <= fsp_pkg::CNT_CMD)
            cmd_q <= {cmd_q[6:0], si_i};                 // msb first
         if (bcnt_q >= fsp_pkg::CNT_CMD && bcnt_q < fsp_pkg::CNT_ADDR && !dseen_q && in_frame_q)
            addr_q <= {addr_q[22:0], si_i};
         if (bcnt_d == fsp_pkg::CNT_CMD)
            busy_q <= stab_q[fsp_pkg::BIT_BUSY];
      end
   end

   // status bits cross per bit, three stages, taken when two agree
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_ssync
         always_ff @(posedge sck_i or posedge rst_i) begin
            if (rst_i) begin
               s1_q[g]   <= 1'b0;
               s2_q[g]   <= 1'b0;
               s3_q[g]   <= 1'b0;
               stab_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= lnk.status[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  stab_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate

   // ****************************
   // output side
   // ****************************
   // status may be read in any cycle state
   assign is_stat = (cmd_q == fsp_pkg::CMD_STAT_RD) && (bcnt_q >= fsp_pkg::CNT_CMD);
   assign is_rd   = (cmd_q == fsp_pkg::CMD_ARR_RD) && (bcnt_q >= fsp_pkg::CNT_ADDR)
                    && !busy_q;
   assign bstart  = (bcnt_q[2:0] == 3'h0);
   assign lnk.rd_addr = (!dseen_q && bcnt_q == fsp_pkg::CNT_ADDR) ?
                        addr_q[20:0] : rda_q;
   assign nbyte   = is_stat ? stab_q : lnk.rd_data;

   // shift out on falling edges, next byte loaded at each boundary
   always_ff @(negedge sck_i or posedge frm_rst) begin
      if (frm_rst) begin
         so_q   <= 1'b0;
         oe_n_q <= 1'b1;
         sr_q   <= 8'h00;
      end else if (is_stat || is_rd) begin
         oe_n_q <= 1'b0;
         so_q   <= bstart ? nbyte[7] : sr_q[7];
         sr_q   <= bstart ? {nbyte[6:0], 1'b0} : {sr_q[6:0], 1'b0};
      end
   end

   // read pointer wraps from top of array to zero
   always_ff @(negedge sck_i or posedge rst_i) begin
      if (rst_i)
         rda_q <= 21'h000000;
      else if (is_rd && bstart)
         rda_q <= lnk.rd_addr + 21'h000001;
   end

   assign lnk.cmd   = cmd_q;
   assign lnk.bcnt  = bcnt_q;
   assign lnk.addr  = addr_q;
   assign lnk.dseen = dseen_q;
   assign so_o      = so_q;
   assign so_oe_n_o = oe_n_q;
endmodule

// File: design/fsp_top.sv
/*
 fsp_top: status byte, write latch, region guards, locked mode, internal
 cycle timing and array store of a serial flash, plus its serial link.
 Assumes: serial clock and select come from an outside host on their own
 clock; array preload happens only while the host is deselected.
*/
// What this block does
// - status read is answered at any time, even during an internal cycle
// - status byte repeats for as long as the host keeps clocking
// - busy flag is one during status write, program and erase cycles
// - write latch shown in status; clear latch refuses all writes
// - guard bits are kept, set only by status write, block protected area
// - whole array erase only when every guard bit is zero
// - lock bit set with guard pin low locks status and refuses status writes
// - status write needs a completed write enable first
// - status write must end with select rise right after the data byte
// - status write leaves b6, b5, b4, b1, b0 unchanged
// - b6, b5 and b4 always read as zero
// - select rise starts timed cycle; busy until done, then latch cleared
// - with pin high or lock clear, status writable once latch is set
// - lock clear: status write accepted whatever the guard pin level
// - locked mode keeps the guarded area protected
// - locked mode entered by whichever of lock bit and pin comes last
// - locked mode left only by guard pin going high
// - array read: command, three address bytes, data out on falling edges
// - read address advances per byte and wraps to zero
// - select rise ends a read at any bit; output released
// - array read during an internal cycle is rejected
// - all bytes travel most significant bit first
// - input bits taken on rising clock from first edge after select
// - completed write enable sets the write latch
`timescale 1ns/1ps
module fsp_top #(
   parameter int SE_CYC = 65536,
   parameter int BE_CYC = 2097152
) (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   // serial link
   input  wire logic        sck_i,
   input  wire logic        sel_n_i,
   input  wire logic        serial_in_i,
   output logic             serial_out_o,
   output logic             serial_out_oe_n_o,
   // write guard pin
   input  wire logic        write_guard_n_i,
   // array preload
   input  wire logic        load_en_i,
   input  wire logic [20:0] load_addr_i,
   input  wire logic [7:0]  load_data_i,
   // observation
   output logic [7:0]       status_o,
   output logic             locked_mode_o
);

   // ****************************
   // declarations
   // ****************************
   fsp_link_if lnk ();

   fsp_pkg::fsp_cyc_e st_q, st_d;

   logic [1:0]  s1_q, s2_q, s3_q;
   logic [1:0]  stab_q;
   logic        sel_prev_q;
   logic        desel_ev;
   logic        sel_hi, wg_hi;

   logic [7:0]  nv_q;
   logic        wel_q;
   logic [7:0]  wd_q;
   logic [20:0] cnt_q;
   logic [20:0] er_addr_q;
   logic [7:0]  status_q;
   logic        locked_q;

   logic        idle;
   logic        c_cmd, c_wrd, c_addr, c_data;
   logic [1:0]  grd;
   logic [5:0]  top_sec;
   logic        prot;
   logic        locked;
   logic        go_wren, go_wrdi, go_wrsr;
   logic        go_prog, go_se, go_be;
   logic        done;
   logic [7:0]  stat_now;

   logic [7:0]  mem [0:(1 << fsp_pkg::MEM_AW) - 1];

   // ****************************
   // link engine
   // ****************************
   fsp_link u_link (
      .sck_i     (sck_i),
      .sel_n_i   (sel_n_i),
      .si_i      (serial_in_i),
      .rst_i     (sys_rst_i),
      .lnk       (lnk.link),
      .so_o      (serial_out_o),
      .so_oe_n_o (serial_out_oe_n_o)
   );

   // ****************************
   // pin synchronisers
   // ****************************
   // bit 0 select, bit 1 guard pin; idle level of both is high
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_psync
         always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               s1_q[g]   <= 1'b1;
               s2_q[g]   <= 1'b1;
               s3_q[g]   <= 1'b1;
               stab_q[g] <= 1'b1;
            end else begin
               s1_q[g] <= (g == 0) ? sel_n_i : write_guard_n_i;
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  stab_q[g] <= s3_q[g];
            end
         end
      end
   endgenerate

   // select rise marks a finished frame
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) sel_prev_q <= 1'b1;
      else           sel_prev_q <= stab_q[0];
   end

   assign sel_hi   = stab_q[0];
   assign wg_hi    = stab_q[1];
   assign desel_ev = sel_hi & !sel_prev_q;

   // ****************************
   // frame decode
   // ****************************
   // link fields are stable here: no clock runs while deselected
   assign idle   = (st_q == fsp_pkg::ST_IDLE);
   assign c_cmd  = !lnk.dseen && (lnk.bcnt == fsp_pkg::CNT_CMD);
   assign c_wrd  = !lnk.dseen && (lnk.bcnt == fsp_pkg::CNT_WRD);
   assign c_addr = !lnk.dseen && (lnk.bcnt == fsp_pkg::CNT_ADDR);
   assign c_data = lnk.dseen && (lnk.bcnt == fsp_pkg::CNT_ADDR);

   // guard region grows from the top of the array
   assign grd     = nv_q[fsp_pkg::BIT_GUARD1:fsp_pkg::BIT_GUARD0];
   assign top_sec = 6'h20 - (6'h01 << (grd - 2'h1));
   assign prot    = (grd != 2'h0)
                    && ({1'b0, lnk.addr[20:16]} >= top_sec);

   // lock bit and low pin, in either order; pin high leaves it
   assign locked = nv_q[fsp_pkg::BIT_LOCK] & !wg_hi;

   assign go_wren = desel_ev && c_cmd && idle
                    && (lnk.cmd == fsp_pkg::CMD_WR_EN);
   assign go_wrdi = desel_ev && c_cmd && idle
                    && (lnk.cmd == fsp_pkg::CMD_WR_DIS);
   // soft guard mode or lock clear: latch alone decides
   assign go_wrsr = desel_ev && c_wrd && idle && wel_q && !locked
                    && (lnk.cmd == fsp_pkg::CMD_STAT_WR);
   assign go_prog = desel_ev && c_data && idle && wel_q && !prot
                    && (lnk.cmd == fsp_pkg::CMD_PROG);
   assign go_se   = desel_ev && c_addr && idle && wel_q && !prot
                    && (lnk.cmd == fsp_pkg::CMD_SECT_ER);
   assign go_be   = desel_ev && c_cmd && idle && wel_q && (grd == 2'h0)
                    && (lnk.cmd == fsp_pkg::CMD_BULK_ER);

   assign done = !idle && (cnt_q == 21'h000000);

   // ****************************
   // internal cycle machine
   // ****************************
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         fsp_pkg::ST_IDLE: begin
            if (go_wrsr)
               st_d = fsp_pkg::ST_WRSR;
            else if (go_prog)
               st_d = fsp_pkg::ST_PROG;
            else if (go_se || go_be)
               st_d = fsp_pkg::ST_ERASE;
         end
         fsp_pkg::ST_WRSR,
         fsp_pkg::ST_PROG,
         fsp_pkg::ST_ERASE: begin
            if (done)
               st_d = fsp_pkg::ST_IDLE;
         end
         default: st_d = fsp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) st_q <= fsp_pkg::ST_IDLE;
      else           st_q <= st_d;
   end

   // cycle length counter, loaded at start, counts down to zero
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         cnt_q <= 21'h000000;
      else if (go_wrsr)
         cnt_q <= 21'(fsp_pkg::TW_CYC - 1);
      else if (go_prog)
         cnt_q <= 21'(fsp_pkg::TPP_CYC - 1);
      else if (go_se)
         cnt_q <= 21'(SE_CYC - 1);
      else if (go_be)
         cnt_q <= 21'(BE_CYC - 1);
      else if (!idle)
         cnt_q <= cnt_q - 21'h000001;
   end

   // erase walks the array one byte per clock
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         er_addr_q <= 21'h000000;
      else if (go_se)
         er_addr_q <= {lnk.addr[20:16], 16'h0000};
      else if (go_be)
         er_addr_q <= 21'h000000;
      else if (st_q == fsp_pkg::ST_ERASE)
         er_addr_q <= er_addr_q + 21'h000001;
   end

   // ****************************
   // status byte
   // ****************************
   // data byte captured now; the next frame may overwrite link fields
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         wd_q <= 8'h00;
      else if (go_wrsr)
         wd_q <= lnk.addr[7:0];
   end

   // guards and lock change only when a status write completes
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         nv_q <= fsp_pkg::STAT_RST;
      else if (done && st_q == fsp_pkg::ST_WRSR)
         nv_q <= (nv_q & ~fsp_pkg::STAT_WMASK)
                 | (wd_q & fsp_pkg::STAT_WMASK);
   end

   // latch: set by write enable, cleared by disable or cycle end
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         wel_q <= 1'b0;
      else if (go_wren)
         wel_q <= 1'b1;
      else if (go_wrdi || done)
         wel_q <= 1'b0;
   end

   // reserved bits masked to zero, flags in the low bits
   always_comb begin
      stat_now = nv_q & fsp_pkg::STAT_WMASK;
      stat_now[fsp_pkg::BIT_BUSY]   = !idle;
      stat_now[fsp_pkg::BIT_WLATCH] = wel_q;
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_q <= fsp_pkg::STAT_RST;
         locked_q <= 1'b0;
      end else begin
         status_q <= stat_now;
         locked_q <= locked;
      end
   end

   assign lnk.status    = status_q;
   assign status_o      = status_q;
   assign locked_mode_o = locked_q;

   // ****************************
   // array store
   // ****************************
   // preload only while deselected and idle, so reads see stable data
   always_ff @(posedge ref_clk_i) begin
      if (st_q == fsp_pkg::ST_ERASE)
         mem[er_addr_q] <= fsp_pkg::ERASED;
      else if (load_en_i && sel_hi && idle)
         mem[load_addr_i] <= load_data_i;
   end

   // read port addressed from the link side
   assign lnk.rd_data = mem[lnk.rd_addr];

endmodule

// File: tb/fsp_top_asserts.sv
/*
 fsp_top_asserts: port-level checks of status, lock and serial output.
 Assumes: bound into fsp_top; sck runs only inside frames.
*/
`timescale 1ns/1ps
module fsp_chk #(
   parameter int SE_CYC = 65536,
   parameter int BE_CYC = 2097152
) (
   // clocks and reset
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       sck_i,
   // link and pins
   input  wire logic       sel_n_i,
   input  wire logic       serial_in_i,
   input  wire logic       serial_out_oe_n_o,
   input  wire logic       write_guard_n_i,
   // observation
   input  wire logic [7:0] status_o,
   input  wire logic       locked_mode_o
);
   // ****************************
   // frame decode
   // ****************************
   logic [5:0] nbit_q;
   logic [7:0] cmd_q;
   // select high clears the count so each frame is decoded afresh
   always_ff @(posedge sck_i or posedge sel_n_i) begin
      if (sel_n_i) begin
         nbit_q <= 6'h00;
      end else if (nbit_q != 6'h3F) begin
         nbit_q <= nbit_q + 6'h01; // saturates, long reads stay decoded
      end
   end
   always_ff @(posedge sck_i) begin
      if (nbit_q < 6'h08) begin
         cmd_q <= {cmd_q[6:0], serial_in_i};
      end
   end
   wire stat_fr = (cmd_q == fsp_pkg::CMD_STAT_RD);
   wire arr_fr  = (cmd_q == fsp_pkg::CMD_ARR_RD);

   // ****************************
   // core domain
   // ****************************
   property p_rsvd_zero;
      @(posedge ref_clk_i) disable iff (sys_rst_i) status_o[6:4] == 3'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bits set");
   property p_lock_enter;
      @(posedge ref_clk_i) disable iff (sys_rst_i) (status_o[7] && !write_guard_n_i) [*6] |-> locked_mode_o;
   endproperty
   a_lock_enter: assert property (p_lock_enter) else $error("locked mode not entered");
   property p_lock_exit;
      @(posedge ref_clk_i) disable iff (sys_rst_i) write_guard_n_i [*6] |-> !locked_mode_o;
   endproperty
   a_lock_exit: assert property (p_lock_exit) else $error("locked mode with pin high");
   property p_lock_hold;
      @(posedge ref_clk_i) disable iff (sys_rst_i) locked_mode_o && $past(locked_mode_o) |-> $stable(status_o[7:2]);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("guard or lock changed when locked");
   property p_start_latch;
      @(posedge ref_clk_i) disable iff (sys_rst_i) $rose(status_o[0]) |-> status_o[1];
   endproperty
   a_start_latch: assert property (p_start_latch) else $error("cycle began without latch");
   property p_end_clear;
      @(posedge ref_clk_i) disable iff (sys_rst_i) $fell(status_o[0]) |-> !status_o[1];
   endproperty
   a_end_clear: assert property (p_end_clear) else $error("latch kept after cycle");
   property p_release;
      @(posedge ref_clk_i) disable iff (sys_rst_i) sel_n_i [*2] |-> serial_out_oe_n_o;
   endproperty
   a_release: assert property (p_release) else $error("output driven while deselected");

   // ****************************
   // link domain
   // ****************************
   property p_stat_out;
      @(posedge sck_i) disable iff (sys_rst_i) (nbit_q >= 6'h08 && stat_fr) |-> !serial_out_oe_n_o;
   endproperty
   a_stat_out: assert property (p_stat_out) else $error("status read not driven");
   property p_early_quiet;
      @(posedge sck_i) disable iff (sys_rst_i) nbit_q < 6'h08 |-> serial_out_oe_n_o;
   endproperty
   a_early_quiet: assert property (p_early_quiet) else $error("driven during command byte");
   property p_arr_wait;
      @(posedge sck_i) disable iff (sys_rst_i) (arr_fr && nbit_q >= 6'h08 && nbit_q < 6'h20) |-> serial_out_oe_n_o;
   endproperty
   a_arr_wait: assert property (p_arr_wait) else $error("driven during address");
   property p_wr_quiet;
      @(posedge sck_i) disable iff (sys_rst_i) (nbit_q >= 6'h08 && !stat_fr && !arr_fr) |-> serial_out_oe_n_o;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("driven on a write frame");

   // main scenarios seen
   c_stat: cover property (@(posedge sck_i) nbit_q == 6'h10 && stat_fr);
   c_lock: cover property (@(posedge ref_clk_i) $rose(locked_mode_o));
   c_busy: cover property (@(posedge ref_clk_i) $fell(status_o[0]));
endmodule

bind fsp_top fsp_chk #(.SE_CYC(SE_CYC), .BE_CYC(BE_CYC)) u_chk (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck_i), .sel_n_i(sel_n_i),
   .serial_in_i(serial_in_i), .serial_out_oe_n_o(serial_out_oe_n_o),
   .write_guard_n_i(write_guard_n_i), .status_o(status_o), .locked_mode_o(locked_mode_o));

// File: tb/fsp_host_model.sv
/*
 fsp_host_model: host controller that clocks whole frames into the flash.
 Assumes: caller spaces frames; 30 ns serial clock made only inside frames.
*/
`timescale 1ns/1ps
module fsp_host (
   // link to the flash
   output logic      sck_o,
   output logic      sel_n_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_n_i
);
   initial begin
      sck_o = 1'b0;
      sel_n_o = 1'b1;
      si_o = 1'b0;
   end
   // one frame of n bits; rx keeps the last 16 bits, drv flags any drive
   task automatic xfer(input int n, input logic [47:0] tx, output logic [15:0] rx, output logic drv);
      logic [47:0] t;
      t = tx;
      rx = 16'h0000;
      drv = 1'b0;
      sel_n_o = 1'b0;
      #15;
      for (int i = 0; i < n; i++) begin
         si_o = t[47]; // msb first
         t = t << 1;
         #15 sck_o = 1'b1; // flash takes the bit on this rise
         rx = {rx[14:0], so_i};
         drv = drv | !so_oe_n_i;
         #15 sck_o = 1'b0;
      end
      #15 sel_n_o = 1'b1; // select rises right after the last bit
      si_o = !si_o; // released line must not hold a stale bit
      #90; // deselect gap above 64 ns
   endtask
endmodule

// File: tb/tb_top.sv
/*
 tb_top: self-checking bench for fsp_top with a host model on the link.
 Assumes: fsp_pkg, fsp_link_if, fsp_link, fsp_top compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   logic        clk, rst, sck, sel_n, si, so, so_oe_n, wg_n, ld_en, locked, drv;
   logic [20:0] ld_addr;
   logic [7:0]  ld_data, status, r, d0, d1;
   logic [15:0] rx, got_v;
   logic [31:0] xs_q = 32'h0000000D;
   logic [15:0] exp_q[$];
   string       nm_q[$];
   event        got_ev;
   int          n_mismatch = 0;
   int          n_checks = 0;

   // 125 MHz core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   fsp_top #(.SE_CYC(16), .BE_CYC(32)) dut (
      .ref_clk_i(clk), .sys_rst_i(rst), .sck_i(sck), .sel_n_i(sel_n), .serial_in_i(si),
      .serial_out_o(so), .serial_out_oe_n_o(so_oe_n), .write_guard_n_i(wg_n), .load_en_i(ld_en),
      .load_addr_i(ld_addr), .load_data_i(ld_data), .status_o(status), .locked_mode_o(locked));
   fsp_host u_host (.sck_o(sck), .sel_n_o(sel_n), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));

   // ****************************
   // helpers
   // ****************************
   function automatic logic [31:0] xs();
      xs_q ^= xs_q << 13;
      xs_q ^= xs_q >> 17;
      xs_q ^= xs_q << 5;
      return xs_q;
   endfunction
   task automatic chk(string nm, logic [15:0] g, logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // oldest note is compared with each result as it appears
   initial forever begin
      @(got_ev);
      chk(nm_q.pop_front(), got_v, exp_q.pop_front());
   end
   task automatic note(string nm, logic [15:0] e, logic [15:0] g);
      nm_q.push_back(nm);
      exp_q.push_back(e);
      got_v = g;
      ->got_ev;
   endtask
   task automatic cmd8(logic [7:0] c);
      u_host.xfer(8, {c, 40'h0}, rx, drv);
   endtask
   task automatic rd();
      u_host.xfer(24, {fsp_pkg::CMD_STAT_RD, 40'h0}, rx, drv);
   endtask
   task automatic wrsr(logic we, logic [7:0] v);
      if (we) begin
         cmd8(fsp_pkg::CMD_WR_EN); // latch first
      end
      u_host.xfer(16, {fsp_pkg::CMD_STAT_WR, v, 32'h0}, rx, drv);
   endtask
   // poll busy, bounded, before the next command
   task automatic idle();
      repeat (10) @(posedge clk);
      for (int i = 0; i < 1000 && status[0] !== 1'b0; i++) @(posedge clk);
   endtask
   task automatic pin(logic v);
      @(posedge clk);
      #1 wg_n = v;
      repeat (8) @(posedge clk);
   endtask
   task automatic load(logic [20:0] a, logic [7:0] v);
      @(posedge clk);
      #1 ld_en = 1'b1;
      ld_addr = a;
      ld_data = v;
      @(posedge clk);
      #1 ld_en = 1'b0;
   endtask
   task automatic tally_and_finish();
      #1;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run length
   initial begin
      #400000;
      n_mismatch++;
      tally_and_finish();
   end

   // ****************************
   // tests
   // ****************************
   initial begin
      rst = 1'b1;
      wg_n = 1'b1;
      ld_en = 1'b0;
      ld_addr = 21'h000000;
      ld_data = 8'h00;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      rd();
      note("status after reset", 16'h0000, rx);
      wrsr(1'b0, 8'h8C);
      repeat (20) @(posedge clk);
      note("unlatched write", 16'h0000, {8'h00, status});
      cmd8(fsp_pkg::CMD_WR_EN);
      rd();
      note("latch set", 16'h0002, {8'h00, rx[7:0]});
      u_host.xfer(17, {fsp_pkg::CMD_STAT_WR, 8'h8C, 32'h0}, rx, drv);
      u_host.xfer(15, {fsp_pkg::CMD_STAT_WR, 8'h8C, 32'h0}, rx, drv);
      rd();
      note("misframed write", 16'h0202, rx);
      $display("test protocol done");
      r = 8'(xs());
      wrsr(1'b1, r);
      rd();
      note("busy read", 16'h0003, {8'h00, rx[7:0]});
      u_host.xfer(48, {fsp_pkg::CMD_ARR_RD, 40'h0}, rx, drv);
      note("read while busy", 16'h0000, {15'h0, drv});
      idle();
      note("written status", {8'h00, r & fsp_pkg::STAT_WMASK}, {8'h00, status});
      $display("test status write done");
      wrsr(1'b1, 8'h84);
      idle();
      pin(1'b0);
      note("locked by pin", 16'h0001, {15'h0, locked});
      wrsr(1'b1, 8'h00);
      repeat (20) @(posedge clk);
      rd();
      note("locked refuses", 16'h0086, {8'h00, rx[7:0]});
      pin(1'b1);
      note("unlocked", 16'h0000, {15'h0, locked});
      wrsr(1'b0, 8'h00);
      idle();
      note("soft mode write", 16'h0000, {8'h00, status});
      pin(1'b0);
      wrsr(1'b1, 8'h04);
      idle();
      note("lock clear write", 16'h0004, {8'h00, status});
      wrsr(1'b1, 8'h88);
      idle();
      repeat (8) @(posedge clk);
      note("locked by bit", 16'h0001, {15'h0, locked});
      pin(1'b1);
      $display("test lock done");
      cmd8(fsp_pkg::CMD_WR_EN);
      cmd8(fsp_pkg::CMD_BULK_ER);
      repeat (20) @(posedge clk);
      note("bulk erase refused", 16'h008A, {8'h00, status});
      $display("test erase done");
      d0 = 8'(xs());
      d1 = 8'(xs());
      load(21'h1FFFFF, d0);
      load(21'h000000, d1);
      u_host.xfer(48, {fsp_pkg::CMD_ARR_RD, 24'hFFFFFF, 16'h0}, rx, drv);
      note("read wrap", {d0, d1}, rx);
      u_host.xfer(13, {fsp_pkg::CMD_STAT_RD, 40'h0}, rx, drv);
      note("partial read driven", 16'h0001, {15'h0, drv});
      $display("test array read done");
      tally_and_finish();
   end
endmodule
